/* File: common/rpf_pkg.sv */
// rpf_pkg: register map, field layout, reset values and timing counts
// for the reset and power-fail sequencer; used by design and bench alike.
package rpf_pkg;

  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LVCTL  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CLEAR  = 8'h0C;
  localparam logic [7:0] OFS_ENABLE = 8'h10;
  localparam logic [7:0] OFS_PC     = 8'h14;

  // control register fields
  localparam int CTRL_PAGE_LSB  = 0;
  localparam int CTRL_PAGE_W    = 8;
  localparam int CTRL_DPAGE_BIT = 8;
  localparam int CTRL_CLKSEL    = 9;
  localparam int CTRL_PCLK_BIT  = 10;
  localparam int CTRL_WDT_BIT   = 11;
  localparam logic [11:0] CTRL_RESET = 12'h000;

  // low-voltage control register fields
  localparam int LV_EN_BIT   = 0;
  localparam int LV_RST_BIT  = 1;
  localparam int LV_FLAG_BIT = 7;
  localparam logic [1:0] LV_RESET = 2'h0;

  // status / clear / enable layout
  localparam int ST_W       = 4;
  localparam int ST_LVFLAG  = 0;
  localparam int ST_WDT_RST = 1;
  localparam int ST_EXT_RST = 2;
  localparam int ST_LV_RST  = 3;

  // vector location
  localparam logic [15:0] VEC_LO_ADDR = 16'hFFFE;
  localparam logic [15:0] VEC_HI_ADDR = 16'hFFFF;

  // timing
  localparam longint CLK_HZ        = 100_000_000;
  localparam longint STARTUP_MS    = 64;
  localparam longint OSC_EXTRA     = 7;
  localparam int     EXT_LOW_MIN   = 8;
  localparam longint STARTUP_CYC   = (STARTUP_MS * CLK_HZ) / 1000 + OSC_EXTRA;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_HOLD = 3'h0,
    ST_WAIT = 3'h1,
    ST_VLO  = 3'h3,
    ST_VHI  = 3'h2,
    ST_RUN  = 3'h6
  } rpf_state_e;

endpackage : rpf_pkg

/* File: design/rpf_top.sv */
// rpf_top: reset sources, start-up delay, vector fetch, low-voltage flag
// and reset, with an AXI4-Lite register slave and one interrupt.
// assumes vector memory answers within the cycle its address is out.
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module rpf_top #(
  parameter int unsigned STARTUP_CYCLES = int'(rpf_pkg::STARTUP_CYC)
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // reset sources
  input  wire logic        ext_reset_n_i,
  input  wire logic        wdt_reset_req_i,
  // detector comparators
  input  wire logic        lv_warn_i,
  input  wire logic        lv_low_i,
  // core side
  output logic             core_reset_o,
  output logic             ram_hold_o,
  output logic             pc_load_o,
  output logic [15:0]      pc_o,
  output logic [15:0]      vec_addr_o,
  output logic             vec_rd_o,
  input  wire logic [7:0]  vec_data_i,
  // initialised state
  output logic [7:0]       ram_page_select_o,
  output logic             direct_page_o,
  output logic             clk_sub_sel_o,
  output logic             periph_clk_en_o,
  output logic             wdt_en_o,
  output logic             lv_detect_en_o,
  // interrupt
  output logic             irq_o,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i
);

  // pin synchronisers
  logic [1:0] ext_sync_r;
  logic [1:0] warn_sync_r;
  logic [1:0] low_sync_r;

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ext_sync_r  <= 2'h3;
      warn_sync_r <= 2'h0;
      low_sync_r  <= 2'h0;
    end
    else
    begin
      ext_sync_r  <= {ext_sync_r[0], ext_reset_n_i};
      warn_sync_r <= {warn_sync_r[0], lv_warn_i};
      low_sync_r  <= {low_sync_r[0], lv_low_i};
    end
  end

  wire ext_n = ext_sync_r[1];
  wire warn  = warn_sync_r[1];
  wire low   = low_sync_r[1];

  // external pin low-time qualifier
  logic [3:0] low_cnt_r;
  logic [3:0] low_cnt_nxt;
  wire        ext_long = (low_cnt_r >= 4'(rpf_pkg::EXT_LOW_MIN));
  assign low_cnt_nxt = ext_n ? 4'h0 : (ext_long ? low_cnt_r : low_cnt_r + 4'h1);

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      low_cnt_r <= 4'h0;
    else
      low_cnt_r <= low_cnt_nxt;
  end

  // registers
  logic [11:0]            ctrl_r;
  logic [1:0]             lvctl_r;
  logic [rpf_pkg::ST_W-1:0] status_r;
  logic [rpf_pkg::ST_W-1:0] enable_r;

  wire lv_en     = lvctl_r[rpf_pkg::LV_EN_BIT];
  wire lv_rst_en = lvctl_r[rpf_pkg::LV_RST_BIT];

  // reset request sources
  wire ext_req = ext_long;
  wire wdt_req = wdt_reset_req_i;
  wire lv_req  = low & lv_en & lv_rst_en;
  wire any_req = ext_req | wdt_req | lv_req;

  // sequencer
  rpf_pkg::rpf_state_e state_r;
  rpf_pkg::rpf_state_e state_nxt;
  logic [31:0]         wait_cnt_r;
  logic [7:0]          vec_lo_r;
  logic [15:0]         pc_r;
  logic                pc_load_r;

  wire wait_done = (wait_cnt_r >= STARTUP_CYCLES - 32'h1);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      rpf_pkg::ST_HOLD: if (!any_req & ext_n) state_nxt = rpf_pkg::ST_WAIT;
      rpf_pkg::ST_WAIT: if (wait_done) state_nxt = rpf_pkg::ST_VLO;
      rpf_pkg::ST_VLO:  state_nxt = rpf_pkg::ST_VHI;
      rpf_pkg::ST_VHI:  state_nxt = rpf_pkg::ST_RUN;
      rpf_pkg::ST_RUN:  state_nxt = rpf_pkg::ST_RUN;
      default:          state_nxt = rpf_pkg::ST_HOLD;
    endcase
    if (any_req)
      state_nxt = rpf_pkg::ST_HOLD;
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      state_r <= rpf_pkg::ST_HOLD;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      wait_cnt_r <= 32'h0;
    else if (state_r != rpf_pkg::ST_WAIT || any_req)
      wait_cnt_r <= 32'h0;
    else
      wait_cnt_r <= wait_cnt_r + 32'h1;
  end

  // vector fetch: each byte is taken at the end of its address cycle
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      vec_lo_r  <= 8'h00;
      pc_r      <= 16'h0000;
      pc_load_r <= 1'b0;
    end
    else
    begin
      pc_load_r <= 1'b0;
      if (state_r == rpf_pkg::ST_VHI && !any_req)
      begin
        pc_r      <= {vec_data_i, vec_lo_r};
        pc_load_r <= 1'b1;
      end
      if (state_r == rpf_pkg::ST_VLO)
        vec_lo_r <= vec_data_i;
    end
  end

  wire in_hold = (state_r == rpf_pkg::ST_HOLD);

  // AXI write path
  logic       aw_got_r;
  logic       w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic       bvalid_r;
  logic [1:0] bresp_r;

  assign s_axi_awready_o = !aw_got_r && !bvalid_r;
  assign s_axi_wready_o  = !w_got_r && !bvalid_r;
  wire   aw_take = s_axi_awvalid_i && s_axi_awready_o;
  wire   w_take  = s_axi_wvalid_i && s_axi_wready_o;
  wire   do_wr   = aw_got_r && w_got_r && !bvalid_r;

  wire [31:0] wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  wire [31:0] wbits = w_data_r & wmask;

  wire wr_ctrl  = do_wr && aw_addr_r == rpf_pkg::OFS_CTRL;
  wire wr_lvctl = do_wr && aw_addr_r == rpf_pkg::OFS_LVCTL;
  wire wr_clear = do_wr && aw_addr_r == rpf_pkg::OFS_CLEAR;
  wire wr_en    = do_wr && aw_addr_r == rpf_pkg::OFS_ENABLE;
  wire wr_ok    = wr_ctrl | wr_lvctl | wr_clear | wr_en;

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= rpf_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr_i;
      end
      if (w_take)
      begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata_i;
        w_strb_r <= s_axi_wstrb_i;
      end
      if (do_wr)
      begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= wr_ok ? rpf_pkg::RESP_OKAY : rpf_pkg::RESP_SLVERR;
      end
      else if (bvalid_r && s_axi_bready_i)
        bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o  = bresp_r;

  // control registers: cleared by every reset sequence, writes ignored in hold
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ctrl_r  <= rpf_pkg::CTRL_RESET;
      lvctl_r <= rpf_pkg::LV_RESET;
    end
    else if (in_hold)
    begin
      ctrl_r  <= rpf_pkg::CTRL_RESET;
      lvctl_r <= rpf_pkg::LV_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= wbits[11:0] | (ctrl_r & ~wmask[11:0]);
      if (wr_lvctl)
        lvctl_r <= wbits[1:0] | (lvctl_r & ~wmask[1:0]);
    end
  end

  // sticky status: events set, clear register clears, set wins
  logic [rpf_pkg::ST_W-1:0] ev;
  logic                     hold_d_r;
  always_comb
  begin
    ev = '0;
    ev[rpf_pkg::ST_LVFLAG]  = warn & lv_en;
    ev[rpf_pkg::ST_WDT_RST] = wdt_req & !hold_d_r;
    ev[rpf_pkg::ST_EXT_RST] = ext_req & !hold_d_r;
    ev[rpf_pkg::ST_LV_RST]  = lv_req & !hold_d_r;
  end

  wire [rpf_pkg::ST_W-1:0] clr = wr_clear ? wbits[rpf_pkg::ST_W-1:0] : '0;

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      status_r <= '0;
      enable_r <= '0;
      hold_d_r <= 1'b1;
    end
    else
    begin
      status_r <= (status_r & ~clr) | ev;
      hold_d_r <= in_hold;
      if (wr_en)
        enable_r <= wbits[rpf_pkg::ST_W-1:0];
    end
  end

  assign irq_o = |(status_r & enable_r);

  // AXI read path
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [31:0] rd_val;
  logic        rd_hit;

  assign s_axi_arready_o = !rvalid_r;
  wire   ar_take = s_axi_arvalid_i && s_axi_arready_o;

  always_comb
  begin
    rd_val = 32'h0;
    rd_hit = 1'b1;
    case (s_axi_araddr_i)
      rpf_pkg::OFS_CTRL:   rd_val[11:0] = ctrl_r;
      rpf_pkg::OFS_LVCTL:
      begin
        rd_val[1:0] = lvctl_r;
        rd_val[rpf_pkg::LV_FLAG_BIT] = status_r[rpf_pkg::ST_LVFLAG];
      end
      rpf_pkg::OFS_STATUS: rd_val[rpf_pkg::ST_W-1:0] = status_r;
      rpf_pkg::OFS_CLEAR:  rd_val = 32'h0;
      rpf_pkg::OFS_ENABLE: rd_val[rpf_pkg::ST_W-1:0] = enable_r;
      rpf_pkg::OFS_PC:     rd_val = {13'h0, state_r, pc_r};
      default:             rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= rpf_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_val;
      rresp_r  <= rd_hit ? rpf_pkg::RESP_OKAY : rpf_pkg::RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready_i)
      rvalid_r <= 1'b0;
  end

  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o  = rdata_r;
  assign s_axi_rresp_o  = rresp_r;

  // core-side outputs
  assign core_reset_o      = (state_r != rpf_pkg::ST_RUN);
  assign ram_hold_o        = in_hold;
  assign pc_load_o         = pc_load_r;
  assign pc_o              = pc_r;
  assign vec_rd_o          = (state_r == rpf_pkg::ST_VLO) || (state_r == rpf_pkg::ST_VHI);
  assign vec_addr_o        = (state_r == rpf_pkg::ST_VHI) ? rpf_pkg::VEC_HI_ADDR : rpf_pkg::VEC_LO_ADDR;
  assign ram_page_select_o = ctrl_r[rpf_pkg::CTRL_PAGE_LSB +: rpf_pkg::CTRL_PAGE_W];
  assign direct_page_o     = ctrl_r[rpf_pkg::CTRL_DPAGE_BIT];
  assign clk_sub_sel_o     = ctrl_r[rpf_pkg::CTRL_CLKSEL];
  assign periph_clk_en_o   = ctrl_r[rpf_pkg::CTRL_PCLK_BIT];
  assign wdt_en_o          = ctrl_r[rpf_pkg::CTRL_WDT_BIT];
  assign lv_detect_en_o    = lv_en;

endmodule : rpf_top

`default_nettype wire

/* File: tb/rpf_partner.sv */
// rpf_partner: reset pin circuit, supply comparators and vector memory
// assumes supply_mv_i is the board supply in millivolts
`timescale 1ns/1ps
`default_nettype none
module rpf_partner #(
  parameter logic [15:0] WARN_MV = 16'h0D48,
  parameter logic [15:0] LOW_MV  = 16'h0898,
  parameter logic [15:0] VECTOR  = 16'hA5C3,
  parameter int          PIN_LOW = 12
) (
  // clock
  input  wire logic        ref_clk_i,
  // stimulus
  input  wire logic        pin_pulse_i,
  input  wire logic [15:0] supply_mv_i,
  input  wire logic [15:0] vec_addr_i,
  // device side
  output logic             ext_reset_n_o,
  output logic             lv_warn_o,
  output logic             lv_low_o,
  output logic [7:0]       vec_data_o
);
  int         cnt_r  = 0;
  logic [7:0] junk_r = 8'h00;
  assign ext_reset_n_o = (cnt_r == 0);
  assign lv_warn_o     = (supply_mv_i <= WARN_MV);
  assign lv_low_o      = (supply_mv_i < LOW_MV);
  // memory answers within the cycle of its address; other places give garbage
  assign vec_data_o    = (vec_addr_i == rpf_pkg::VEC_LO_ADDR) ? VECTOR[7:0] :
                         (vec_addr_i == rpf_pkg::VEC_HI_ADDR) ? VECTOR[15:8] : junk_r;
  always @(posedge ref_clk_i)
  begin
    cnt_r  <= pin_pulse_i ? PIN_LOW : (cnt_r == 0 ? 0 : cnt_r - 1);
    junk_r <= ~junk_r;
  end
endmodule : rpf_partner
`default_nettype wire

/* File: tb/rpf_chk.sv */
// rpf_chk: port checks of the reset sequencer
// assumes one clock domain with reset_i as its async reset
`timescale 1ns/1ps
`default_nettype none
module rpf_chk #(
  parameter int unsigned STARTUP_CYCLES = 20
) (
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  // watched ports
  input wire logic        ext_reset_n_i,
  input wire logic        wdt_reset_req_i,
  input wire logic        core_reset_o,
  input wire logic        ram_hold_o,
  input wire logic        pc_load_o,
  input wire logic [15:0] vec_addr_o,
  input wire logic        vec_rd_o,
  input wire logic [7:0]  ram_page_select_o,
  input wire logic        direct_page_o,
  input wire logic        clk_sub_sel_o,
  input wire logic        periph_clk_en_o,
  input wire logic        wdt_en_o,
  input wire logic        lv_detect_en_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  int unsigned cnt_r;
  // cycles since the hold state was left
  always_ff @(posedge ref_clk_i or posedge reset_i)
    if (reset_i)
      cnt_r <= 0;
    else if (ram_hold_o)
      cnt_r <= 0;
    else
      cnt_r <= cnt_r + 1;
  chk_wdt_reset: assert property (wdt_reset_req_i |=> core_reset_o)
    else $error("watchdog request did not reset");
  chk_pin_reset: assert property (!ext_reset_n_i [*8] ##1 !ext_reset_n_i [*4] |=> core_reset_o)
    else $error("long pin low did not reset");
  chk_init_state: assert property (ram_hold_o && $past(ram_hold_o) |->
    {wdt_en_o, periph_clk_en_o, clk_sub_sel_o, direct_page_o, ram_page_select_o, lv_detect_en_o} == 13'h0000)
    else $error("state not initialised in hold");
  chk_start_delay: assert property (pc_load_o |-> cnt_r == STARTUP_CYCLES + 2)
    else $error("start-up delay wrong");
  chk_vec_fetch: assert property (pc_load_o |-> $past(vec_addr_o, 2) == 16'hFFFE &&
    $past(vec_addr_o) == 16'hFFFF && $past(vec_rd_o))
    else $error("vector fetch order wrong");
  chk_run_release: assert property ($fell(core_reset_o) |-> pc_load_o)
    else $error("run without vector load");
  chk_ram_guard: assert property ($rose(core_reset_o) |-> ram_hold_o)
    else $error("ram not held on reset");
  chk_lv_gate: assert property (!core_reset_o && ext_reset_n_i && $past(ext_reset_n_i) &&
    $past(ext_reset_n_i, 2) && $past(ext_reset_n_i, 3) && !wdt_reset_req_i && !lv_detect_en_o &&
    !$past(lv_detect_en_o, 3) |=> !core_reset_o)
    else $error("reset with detector off");
  cov_boot: cover property (pc_load_o);
  cov_wdt: cover property (wdt_reset_req_i && !core_reset_o);
  cov_lv: cover property ($rose(ram_hold_o) && ext_reset_n_i && !wdt_reset_req_i);
endmodule : rpf_chk
bind rpf_top rpf_chk #(.STARTUP_CYCLES(STARTUP_CYCLES)) rpf_chk_inst (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .ext_reset_n_i(ext_reset_n_i),
  .wdt_reset_req_i(wdt_reset_req_i), .core_reset_o(core_reset_o), .ram_hold_o(ram_hold_o),
  .pc_load_o(pc_load_o), .vec_addr_o(vec_addr_o), .vec_rd_o(vec_rd_o),
  .ram_page_select_o(ram_page_select_o), .direct_page_o(direct_page_o), .clk_sub_sel_o(clk_sub_sel_o),
  .periph_clk_en_o(periph_clk_en_o), .wdt_en_o(wdt_en_o), .lv_detect_en_o(lv_detect_en_o));
`default_nettype wire

/* File: tb/tb_rpf_top.sv */
// tb_rpf_top: register-level tests of the reset and power-fail sequencer
// assumes rpf_partner supplies the pin, comparators and vector memory
`timescale 1ns/1ps
`default_nettype none
module tb_rpf_top;
  logic        ref_clk_i, reset_i, wdt_req, pin_pulse, ext_n, warn, low, core_reset, ram_hold, pc_load;
  logic        vec_rd, direct, clk_sub, periph, wdt_en, lv_en, irq, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  wstrb;
  logic [7:0]  vec_data, page, awaddr, araddr;
  logic [12:0] init_st;
  logic [15:0] pc, vec_addr, supply;
  logic [31:0] wdata, rdata, q;
  int          num_errors, tests_run, cyc;
  assign init_st = {wdt_en, periph, clk_sub, direct, page, lv_en};
  rpf_top #(.STARTUP_CYCLES(20)) rpf_top_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .ext_reset_n_i(ext_n), .wdt_reset_req_i(wdt_req), .lv_warn_i(warn), .lv_low_i(low),
    .core_reset_o(core_reset), .ram_hold_o(ram_hold), .pc_load_o(pc_load), .pc_o(pc),
    .vec_addr_o(vec_addr), .vec_rd_o(vec_rd), .vec_data_i(vec_data), .ram_page_select_o(page),
    .direct_page_o(direct), .clk_sub_sel_o(clk_sub), .periph_clk_en_o(periph), .wdt_en_o(wdt_en),
    .lv_detect_en_o(lv_en), .irq_o(irq), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
  rpf_partner rpf_partner_inst (.ref_clk_i(ref_clk_i), .pin_pulse_i(pin_pulse), .supply_mv_i(supply),
    .vec_addr_i(vec_addr), .ext_reset_n_o(ext_n), .lv_warn_o(warn), .lv_low_o(low), .vec_data_o(vec_data));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one bus transfer; handshakes seen mid-cycle are taken at the next edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, hs;
    @(posedge ref_clk_i);
    if (w)
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    else
      {araddr, arvalid, rready} <= {a, 2'h3};
    do
    begin
      @(negedge ref_clk_i);
      ah = (awvalid & awready) | (arvalid & arready);
      wh = wvalid & wready;
      hs = w ? bvalid : rvalid;
      q = rdata;
      r = w ? bresp : rresp;
      @(posedge ref_clk_i);
      if (ah)
        {awvalid, arvalid} <= 2'h0;
      if (wh)
        wvalid <= 1'h0;
    end
    while (!hs);
    {bready, rready} <= 2'h0;
  endtask : acc
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    acc(1'h0, a, 32'h0);
    chk(q, e);
    chk({30'h0, r}, {30'h0, rpf_pkg::RESP_OKAY});
  endtask : rchk
  task automatic boot();
    do @(negedge ref_clk_i); while (pc_load !== 1'h1);
    repeat (2) @(posedge ref_clk_i);
    chk({16'h0, pc}, 32'h0000A5C3);
  endtask : boot
  initial
  begin
    ref_clk_i = 1'h0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      summarize();
    end
  end
  initial
  begin
    {reset_i, wdt_req, pin_pulse, awvalid, wvalid, bready, arvalid, rready} = 8'h80;
    {awaddr, araddr, wdata, wstrb, supply} = {16'h0, 32'h0, 4'hF, 16'h1388};
    repeat (4) @(posedge ref_clk_i);
    reset_i <= 1'h0;
    boot();
    rchk(rpf_pkg::OFS_CTRL, 32'h0);
    acc(1'h1, rpf_pkg::OFS_CTRL, 32'hFFF);
    acc(1'h1, rpf_pkg::OFS_LVCTL, 32'h3);
    chk({19'h0, init_st}, 32'h1FFF);
    $display("boot test done");
    wdt_req <= 1'h1;
    @(posedge ref_clk_i);
    wdt_req <= 1'h0;
    @(negedge ref_clk_i);
    chk({31'h0, core_reset}, 32'h1);
    boot();
    chk({19'h0, init_st}, 32'h0);
    rchk(rpf_pkg::OFS_STATUS, 32'h2);
    pin_pulse <= 1'h1;
    @(posedge ref_clk_i);
    pin_pulse <= 1'h0;
    boot();
    rchk(rpf_pkg::OFS_STATUS, 32'h6);
    acc(1'h1, rpf_pkg::OFS_CLEAR, 32'hF);
    rchk(rpf_pkg::OFS_STATUS, 32'h0);
    $display("reset source test done");
    acc(1'h1, rpf_pkg::OFS_ENABLE, 32'h1);
    acc(1'h1, rpf_pkg::OFS_LVCTL, 32'h1);
    supply <= 16'h0CE4;
    repeat (6) @(posedge ref_clk_i);
    supply <= 16'h1388;
    repeat (6) @(posedge ref_clk_i);
    rchk(rpf_pkg::OFS_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    acc(1'h1, rpf_pkg::OFS_ENABLE, 32'h0);
    chk({31'h0, irq}, 32'h0);
    acc(1'h1, rpf_pkg::OFS_ENABLE, 32'h1);
    acc(1'h1, rpf_pkg::OFS_CLEAR, 32'h1);
    rchk(rpf_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("flag test done");
    supply <= 16'h07D0;
    repeat (10) @(posedge ref_clk_i);
    chk({31'h0, core_reset}, 32'h0);
    acc(1'h1, rpf_pkg::OFS_LVCTL, 32'h3);
    repeat (4) @(posedge ref_clk_i);
    chk({31'h0, core_reset}, 32'h1);
    supply <= 16'h1388;
    boot();
    rchk(rpf_pkg::OFS_STATUS, 32'h9);
    chk({19'h0, init_st}, 32'h0);
    $display("low-voltage test done");
    acc(1'h0, 8'h20, 32'h0);
    chk({q[29:0], r}, {30'h0, rpf_pkg::RESP_SLVERR});
    acc(1'h1, rpf_pkg::OFS_PC, 32'h0);
    chk({30'h0, r}, {30'h0, rpf_pkg::RESP_SLVERR});
    $display("bus test done");
    summarize();
  end
endmodule : tb_rpf_top
`default_nettype wire
